// >>> shared/jisp_pkg.sv
// constants and types of the in-circuit reprogramming host controller
package jisp_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_LAST = 2'h3;
  localparam int TCK_BIT = 1;
  localparam int IR_LEN = 10;
  localparam int DR_W = 32;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LEN_W = 6;
  localparam logic [LEN_W-1:0] RST_LAST = 6'h04;
  localparam int ERASE_MS = 350;
  localparam int PROG_US = 75;
  localparam int VREAD_US = 1;
  localparam int RELOAD_US = 300;
  localparam int ERASE_CYC = (ERASE_MS * (CLK_HZ / 1000) + 999) / 1000 * 1000;
  localparam int PROG_CYC = (PROG_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int VREAD_CYC = (VREAD_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int RELOAD_CYC = (RELOAD_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int DW_W = 25;
  localparam logic [9:0] INS_ENTER = 10'h2C0;
  localparam logic [9:0] INS_IDCODE = 10'h006;
  localparam logic [9:0] INS_ERASE = 10'h2D0;
  localparam logic [9:0] INS_LOAD = 10'h2E0;
  localparam logic [9:0] INS_PROG = 10'h2F0;
  localparam logic [9:0] INS_VERIFY = 10'h300;
  localparam logic [9:0] INS_EXIT = 10'h310;
  localparam logic [9:0] INS_RELOAD = 10'h320;
  // expected silicon id, value arbitrary
  localparam logic [DR_W-1:0] EXPECT_ID = 32'h1234ABCD;
  localparam logic [ADDR_W-1:0] CFG_BASE = 16'h0000;
  localparam logic [ADDR_W-1:0] CFG_LAST = 16'h00FF;
  localparam logic [ADDR_W-1:0] USR_BASE = 16'h8000;
  localparam logic [ADDR_W-1:0] USR_LAST = 16'h001F;
  typedef enum logic [3:0] {
    T_IDLE = 4'h0, T_RST = 4'h1, T_SELDR = 4'h2, T_SELIR = 4'h3,
    T_CAP = 4'h4, T_ENSH = 4'h5, T_SH = 4'h6, T_UPD = 4'h7,
    T_RTI = 4'h8, T_DWELL = 4'h9
  } jisp_tap_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ENTER = 4'h1, S_IDIR = 4'h2, S_IDDR = 4'h3,
    S_IDCHK = 4'h4, S_ERASE = 4'h5, S_PLOAD = 4'h6, S_PDR = 4'h7,
    S_PPROG = 4'h8, S_VLOAD = 4'h9, S_VDR = 4'hA, S_VIR = 4'hB,
    S_VRD = 4'hC, S_VCHK = 4'hD, S_EXIT = 4'hE, S_RELOAD = 4'hF
  } jisp_stage_t;
endpackage : jisp_pkg

// >>> design/jisp_programmer.sv
// host that reprograms the flash device over its four-pin test port
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RL1] all programming over four test port pins
// [RL2] start only after supplies and power-up done
// [RL3] device floats pulled-up pins while programming
// [RL4] completion flag is the last bit written
// [RL5] send on TDI, compare data read on TDO
// [RL6] six stages in order; verify uses 1,2,5,6
// [RL7] device moves pins glitch-free entering, leaving
// [RL8] check silicon id before program or verify
// [RL9] erase: instruction then 350 ms idle dwell
// [RL10] program: address, data, instruction, 75 us dwell
// [RL11] repeat program for every flash address
// [RL12] verify: address, instruction, read pulse, shift out
// [RL13] test clock never above 25 MHz
// [RL14] user store and config flash separately programmable
// [RL15] reprogram allowed while design keeps running
// [RL16] new image normally loads at next power cycle
// [RL17] command sequence forces immediate reload
// [RL18] security bit refuses config flash readback
// [RL19] only erase clears the security bit
// [RL20] volatile configuration never readable
// [RL21] user store readable despite security bit
// [RL22] instruction register is 10 bits
// [RL23] device ignores commands outside programming mode
module jisp_programmer #(
  parameter int ERASE_CYC = jisp_pkg::ERASE_CYC,
  parameter int RELOAD_CYC = jisp_pkg::RELOAD_CYC,
  parameter int PROG_CYC = jisp_pkg::PROG_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic verify_only,
  input wire logic target_user,
  input wire logic reload_now,
  input wire logic read_secured,
  input wire logic power_good,
  output logic [jisp_pkg::ADDR_W-1:0] img_addr,
  input wire logic [jisp_pkg::DATA_W-1:0] img_data,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  output logic busy,
  output logic done,
  output logic id_fail,
  output logic verify_fail,
  output logic readback_refused
);
  logic [jisp_pkg::DIV_W-1:0] div_reg;
  logic ev;
  logic tdo_s1_reg, tdo_s2_reg, pg_s1_reg, pg_s2_reg;
  jisp_pkg::jisp_tap_t tap_reg;
  jisp_pkg::jisp_stage_t st_reg;
  logic [jisp_pkg::LEN_W-1:0] cnt_reg, sh_n_reg;
  logic [jisp_pkg::DR_W-1:0] tx_reg, rx_reg;
  logic [jisp_pkg::DW_W-1:0] dw_reg;
  logic tms_reg, tdi_reg, ir_reg, fst_reg;
  logic issue, op_ir, last, ready;
  logic [jisp_pkg::LEN_W-1:0] op_len;
  logic [jisp_pkg::DR_W-1:0] op_tx;
  logic [jisp_pkg::DW_W-1:0] op_dw;
  logic [jisp_pkg::ADDR_W-1:0] addr_reg, dev_addr;
  logic vo_reg, tu_reg, rl_reg, fin_reg, done_reg;
  logic idf_reg, vf_reg, ref_reg;

  ////////////////////////////////////////////////////////////////////////////
  // test clock divider and pin synchronisers
  always_ff @(posedge clk) begin
    if (!resetn) div_reg <= '0;
    else div_reg <= div_reg + 2'h1; // see [RL13]
  end
  assign ev = (div_reg == jisp_pkg::DIV_LAST);
  assign tck = div_reg[jisp_pkg::TCK_BIT]; // see [RL1]
  assign tms = tms_reg;
  assign tdi = tdi_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tdo_s1_reg <= 1'b0;
      tdo_s2_reg <= 1'b0;
      pg_s1_reg <= 1'b0;
      pg_s2_reg <= 1'b0;
    end else begin
      tdo_s1_reg <= tdo;
      tdo_s2_reg <= tdo_s1_reg;
      pg_s1_reg <= power_good;
      pg_s2_reg <= pg_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port walker: pins change as tck falls, tdo sampled just before
  assign ready = (tap_reg == jisp_pkg::T_IDLE);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tap_reg <= jisp_pkg::T_RST;
      cnt_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      dw_reg <= '0;
      tms_reg <= 1'b1;
      tdi_reg <= 1'b0;
      ir_reg <= 1'b0;
      fst_reg <= 1'b0;
    end else begin
      case (tap_reg)
        jisp_pkg::T_IDLE: begin
          if (issue) begin
            tap_reg <= jisp_pkg::T_SELDR;
            cnt_reg <= op_len - 6'h01;
            tx_reg <= op_tx;
            dw_reg <= op_dw;
            ir_reg <= op_ir;
          end
        end
        jisp_pkg::T_DWELL: begin
          // pulse time counted in clk cycles while idling in run-test
          if (dw_reg != '0) dw_reg <= dw_reg - 25'h0000001;
          else if (ev) tap_reg <= jisp_pkg::T_IDLE;
        end
        default: begin
          if (ev) begin
            case (tap_reg)
              jisp_pkg::T_RST: begin
                tms_reg <= 1'b1;
                cnt_reg <= cnt_reg + 6'h01;
                if (cnt_reg == jisp_pkg::RST_LAST) tap_reg <= jisp_pkg::T_RTI;
              end
              jisp_pkg::T_SELDR: begin
                tms_reg <= 1'b1;
                tap_reg <= ir_reg ? jisp_pkg::T_SELIR : jisp_pkg::T_CAP;
              end
              jisp_pkg::T_SELIR: begin
                tms_reg <= 1'b1;
                tap_reg <= jisp_pkg::T_CAP;
              end
              jisp_pkg::T_CAP: begin
                tms_reg <= 1'b0;
                tap_reg <= jisp_pkg::T_ENSH;
              end
              jisp_pkg::T_ENSH: begin
                tms_reg <= 1'b0;
                fst_reg <= 1'b1;
                tap_reg <= jisp_pkg::T_SH;
              end
              jisp_pkg::T_SH: begin
                tdi_reg <= tx_reg[0]; // see [RL5]
                tx_reg <= tx_reg >> 1;
                tms_reg <= (cnt_reg == '0);
                fst_reg <= 1'b0;
                if (!fst_reg) rx_reg <= {tdo_s2_reg, rx_reg[jisp_pkg::DR_W-1:1]};
                if (cnt_reg == '0) tap_reg <= jisp_pkg::T_UPD;
                else cnt_reg <= cnt_reg - 6'h01;
              end
              jisp_pkg::T_UPD: begin
                rx_reg <= {tdo_s2_reg, rx_reg[jisp_pkg::DR_W-1:1]}; // see [RL5]
                tms_reg <= 1'b1;
                tap_reg <= jisp_pkg::T_RTI;
              end
              jisp_pkg::T_RTI: begin
                tms_reg <= 1'b0;
                tap_reg <= jisp_pkg::T_DWELL;
              end
              default: tap_reg <= jisp_pkg::T_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage sequencer: one scan operation per stage step, except IDLE, IDCHK and VCHK
  assign dev_addr = addr_reg + (tu_reg ? jisp_pkg::USR_BASE : jisp_pkg::CFG_BASE);
  assign last = (addr_reg == (tu_reg ? jisp_pkg::USR_LAST : jisp_pkg::CFG_LAST));
  always_comb begin
    issue = 1'b0;
    op_ir = 1'b1;
    op_len = 6'(jisp_pkg::IR_LEN); // see [RL22]
    op_tx = '0;
    op_dw = '0;
    if (ready) begin
      case (st_reg)
        jisp_pkg::S_ENTER: op_tx = 32'(jisp_pkg::INS_ENTER);
        jisp_pkg::S_IDIR: op_tx = 32'(jisp_pkg::INS_IDCODE);
        jisp_pkg::S_IDDR: begin
          op_ir = 1'b0;
          op_len = 6'(jisp_pkg::DR_W);
        end
        jisp_pkg::S_ERASE: begin
          op_tx = 32'(jisp_pkg::INS_ERASE);
          op_dw = 25'(ERASE_CYC); // see [RL9]
        end
        jisp_pkg::S_PLOAD, jisp_pkg::S_VLOAD: op_tx = 32'(jisp_pkg::INS_LOAD);
        jisp_pkg::S_PDR: begin
          op_ir = 1'b0;
          op_len = 6'(jisp_pkg::DR_W);
          op_tx = {img_data, dev_addr};
        end
        jisp_pkg::S_PPROG: begin
          op_tx = 32'(jisp_pkg::INS_PROG);
          op_dw = 25'(PROG_CYC); // see [RL10]
        end
        jisp_pkg::S_VDR: begin
          op_ir = 1'b0;
          op_len = 6'(jisp_pkg::DR_W);
          op_tx = 32'(dev_addr);
        end
        jisp_pkg::S_VIR: begin
          op_tx = 32'(jisp_pkg::INS_VERIFY);
          op_dw = 25'(jisp_pkg::VREAD_CYC); // see [RL12]
        end
        jisp_pkg::S_VRD: begin
          op_ir = 1'b0;
          op_len = 6'(jisp_pkg::DATA_W);
        end
        jisp_pkg::S_EXIT: op_tx = 32'(jisp_pkg::INS_EXIT);
        jisp_pkg::S_RELOAD: begin
          op_tx = 32'(jisp_pkg::INS_RELOAD);
          op_dw = 25'(RELOAD_CYC); // see [RL17]
        end
        default: op_tx = '0;
      endcase
      issue = !(st_reg inside {jisp_pkg::S_IDLE, jisp_pkg::S_IDCHK,
                               jisp_pkg::S_VCHK});
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= jisp_pkg::S_IDLE;
      addr_reg <= '0;
      vo_reg <= 1'b0;
      tu_reg <= 1'b0;
      rl_reg <= 1'b0;
      fin_reg <= 1'b0;
      done_reg <= 1'b0;
      idf_reg <= 1'b0;
      vf_reg <= 1'b0;
      ref_reg <= 1'b0;
    end else if (ready) begin
      case (st_reg)
        jisp_pkg::S_IDLE: begin
          if (fin_reg) begin
            fin_reg <= 1'b0;
            done_reg <= 1'b1;
          end else if (start && pg_s2_reg) begin // see [RL2]
            st_reg <= jisp_pkg::S_ENTER; // see [RL23]
            vo_reg <= verify_only;
            tu_reg <= target_user; // see [RL14]
            rl_reg <= reload_now; // see [RL16]
            addr_reg <= '0;
            done_reg <= 1'b0;
            idf_reg <= 1'b0;
            vf_reg <= 1'b0;
            ref_reg <= 1'b0;
          end
        end
        jisp_pkg::S_IDCHK: begin
          if (rx_reg != jisp_pkg::EXPECT_ID) begin // see [RL8]
            idf_reg <= 1'b1;
            st_reg <= jisp_pkg::S_EXIT;
          end else begin
            st_reg <= vo_reg ? jisp_pkg::S_VLOAD : jisp_pkg::S_ERASE; // see [RL6]
          end
        end
        jisp_pkg::S_PPROG: begin
          // ascending order leaves the completion flag word for last
          addr_reg <= last ? '0 : addr_reg + 16'h0001; // see [RL4]
          st_reg <= last ? jisp_pkg::S_VLOAD : jisp_pkg::S_PLOAD; // see [RL11]
        end
        jisp_pkg::S_VCHK: begin
          if (read_secured && !tu_reg) begin // see [RL18]
            ref_reg <= 1'b1;
            st_reg <= jisp_pkg::S_EXIT;
          end else begin
            if (rx_reg[jisp_pkg::DR_W-1 -: jisp_pkg::DATA_W] != img_data)
              vf_reg <= 1'b1; // see [RL12], [RL21]
            addr_reg <= addr_reg + 16'h0001;
            st_reg <= last ? jisp_pkg::S_EXIT : jisp_pkg::S_VLOAD;
          end
        end
        jisp_pkg::S_EXIT: begin
          fin_reg <= !rl_reg;
          st_reg <= rl_reg ? jisp_pkg::S_RELOAD : jisp_pkg::S_IDLE; // see [RL6]
        end
        jisp_pkg::S_RELOAD: begin
          fin_reg <= 1'b1;
          st_reg <= jisp_pkg::S_IDLE;
        end
        default: st_reg <= jisp_pkg::jisp_stage_t'(st_reg + 4'h1);
      endcase
    end
  end

  assign img_addr = addr_reg;
  assign busy = (st_reg != jisp_pkg::S_IDLE) || fin_reg || !ready;
  assign done = done_reg;
  assign id_fail = idf_reg;
  assign verify_fail = vf_reg;
  assign readback_refused = ref_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge clk) begin
    if (!resetn || ready) sh_n_reg <= '0;
    else if (ev && tap_reg == jisp_pkg::T_SH) sh_n_reg <= sh_n_reg + 6'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_tck_cycle;
    tck ##1 !tck ##1 !tck ##1 tck;
  endsequence
  sequence s_enter_erase;
    st_reg == jisp_pkg::S_IDCHK && ready ##1 st_reg == jisp_pkg::S_ERASE;
  endsequence

  property p_tck_div;
    $rose(tck) |-> ##1 s_tck_cycle;
  endproperty
  a_tck_div: assert property (p_tck_div) else $error("tck period wrong"); // see [RL13]
  property p_pins_on_fall;
    ($changed(tms) || $changed(tdi)) |-> $fell(tck);
  endproperty
  a_pins_on_fall: assert property (p_pins_on_fall) else $error("pin moved off fall"); // see [RL1]
  property p_ir_len;
    ($rose(tap_reg == jisp_pkg::T_UPD) && ir_reg) |-> sh_n_reg == 6'(jisp_pkg::IR_LEN);
  endproperty
  a_ir_len: assert property (p_ir_len) else $error("instruction not 10 bits"); // see [RL22]
  property p_id_gate;
    $rose(st_reg == jisp_pkg::S_ERASE) |-> $past(rx_reg) == jisp_pkg::EXPECT_ID;
  endproperty
  a_id_gate: assert property (p_id_gate) else $error("erase without id match"); // see [RL8]
  property p_erase_dwell;
    (issue && st_reg == jisp_pkg::S_ERASE) |=> dw_reg == ERASE_CYC ##1 !ready;
  endproperty
  a_erase_dwell: assert property (p_erase_dwell) else $error("erase dwell wrong"); // see [RL9]
  property p_prog_dwell;
    (issue && st_reg == jisp_pkg::S_PPROG) |=> dw_reg == PROG_CYC;
  endproperty
  a_prog_dwell: assert property (p_prog_dwell) else $error("program dwell wrong"); // see [RL10]
  property p_stage_order;
    s_enter_erase |-> !vo_reg ##1 st_reg == jisp_pkg::S_PLOAD;
  endproperty
  a_stage_order: assert property (p_stage_order) else $error("erase in verify run"); // see [RL6]
  property p_vfail;
    (ready && st_reg == jisp_pkg::S_VCHK && !(read_secured && !tu_reg) &&
     rx_reg[jisp_pkg::DR_W-1 -: jisp_pkg::DATA_W] != img_data) |=> verify_fail;
  endproperty
  a_vfail: assert property (p_vfail) else $error("mismatch not flagged"); // see [RL12]
  property p_refuse;
    (ready && st_reg == jisp_pkg::S_VCHK && read_secured && !tu_reg)
      |=> readback_refused && st_reg == jisp_pkg::S_EXIT;
  endproperty
  a_refuse: assert property (p_refuse) else $error("secured read not refused"); // see [RL18]
endmodule : jisp_programmer
`default_nettype wire

// >>> verif/jisp_dev_model.sv
// behavioural flash device on the far side of the four-pin test port
`timescale 1ns/1ps
`default_nettype none
module jisp_dev_model #(
  parameter int ERASE_T = 49,
  parameter int PROG_T = 936,
  parameter int VREAD_T = 11,
  parameter int RELOAD_T = 24
) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  input wire logic secured,
  output logic io_hiz
);
  int t1[12] = '{0, 2, 3, 0, 8, 9, 8, 9, 10, 11, 2, 2};
  int t0[12] = '{1, 1, 4, 5, 6, 7, 6, 7, 6, 7, 1, 1};
  int st = 0;
  int cnt = 0;
  int erase_n = 0;
  int reload_n = 0;
  logic [9:0] ir = 10'h000;
  logic [9:0] isr = 10'h000;
  logic [31:0] sr = 32'h00000000;
  logic [15:0] a = 16'h0000;
  logic [15:0] d = 16'h0000;
  logic [15:0] mem [logic [15:0]];
  logic [31:0] id_word = jisp_pkg::EXPECT_ID;
  logic mode = 1'b0, pend = 1'b0, vok = 1'b0;
  logic reloading = 1'b0, flag_ok = 1'b1;
  logic tdo_r = 1'b0;
  realtime tr = 0.0;
  realtime minp = 1.0e9;
  function automatic logic [15:0] raw(input logic [15:0] x);
    return mem.exists(x) ? mem[x] : 16'hFFFF;
  endfunction : raw
  function automatic logic [15:0] rd(input logic [15:0] x);
    if (secured && x < jisp_pkg::USR_BASE)
      return 16'h0000;
    return raw(x);
  endfunction : rd
  function automatic int thr(input logic [9:0] i);
    if (i == jisp_pkg::INS_ERASE) return ERASE_T;
    if (i == jisp_pkg::INS_PROG) return PROG_T;
    if (i == jisp_pkg::INS_VERIFY) return VREAD_T;
    return RELOAD_T;
  endfunction : thr
  assign io_hiz = mode | reloading
    | !flag_ok;
  assign tdo = tdo_r;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge tck) begin
    if ($realtime - tr < minp) minp = $realtime - tr;
    tr = $realtime;
    case (st)
      4: sr = (ir == jisp_pkg::INS_IDCODE) ? id_word
            : {16'h0000, vok ? rd(a) : 16'h0000};
      5: isr = 10'h001;
      6: sr = {tdi, sr[31:1]};
      7: isr = {tdi, isr[9:1]};
      10: if (ir == jisp_pkg::INS_LOAD && mode) begin
        a = sr[15:0];
        d = sr[31:16];
      end
      11: begin
        ir = isr;
        cnt = 0;
        vok = 1'b0;
        pend = isr == jisp_pkg::INS_RELOAD || (mode &&
          (isr == jisp_pkg::INS_ERASE || isr == jisp_pkg::INS_PROG ||
          isr == jisp_pkg::INS_VERIFY));
        reloading = isr == jisp_pkg::INS_RELOAD;
        mode = isr == jisp_pkg::INS_ENTER ||
          (mode && isr != jisp_pkg::INS_EXIT);
      end
      1: begin
        if (tms) begin
          pend = 1'b0;
          reloading = 1'b0;
        end else if (pend) begin
          cnt++;
          if (cnt == thr(ir)) begin
            pend = 1'b0;
            if (ir == jisp_pkg::INS_ERASE) begin
              mem.delete();
              erase_n++;
              flag_ok = 1'b0;
            end else if (ir == jisp_pkg::INS_PROG) begin
              mem[a] = raw(a) & d;
              if (a == jisp_pkg::CFG_LAST ||
                  a == jisp_pkg::USR_BASE + jisp_pkg::USR_LAST)
                flag_ok = 1'b1;
            end else if (ir == jisp_pkg::INS_VERIFY) begin
              vok = 1'b1;
            end else begin
              reload_n++;
              reloading = 1'b0;
            end
          end
        end
      end
      default: ;
    endcase
    st = tms ? t1[st] : t0[st];
  end
  always @(negedge tck) begin
    tdo_r <= (st == 6) ? sr[0] : (st == 7) ? isr[0] : ~tdo_r;
  end
endmodule : jisp_dev_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the reprogramming host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int ERASE_C = 200;
  localparam int RELOAD_C = 100;
  localparam int PROG_C = 100;
  localparam logic [15:0] UB = jisp_pkg::USR_BASE;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic verify_only = 1'b0;
  logic target_user = 1'b1;
  logic reload_now = 1'b0;
  logic read_secured = 1'b0;
  logic power_good = 1'b0;
  logic [15:0] img_addr;
  logic [15:0] img_data = 16'h0000;
  logic tck, tms, tdi, tdo, busy, done, id_fail, verify_fail, readback_refused;
  logic [15:0] img [256];
  int fail_count = 0;
  int n_compared = 0;
  integer seed = 32'hafcb;
  int e0;
  always #10 clk = ~clk;
  always @(posedge clk) img_data <= #1 img[img_addr[7:0]];
  jisp_programmer #(.ERASE_CYC(ERASE_C), .RELOAD_CYC(RELOAD_C),
    .PROG_CYC(PROG_C)) dut (
    .clk(clk), .resetn(resetn), .start(start), .verify_only(verify_only),
    .target_user(target_user), .reload_now(reload_now),
    .read_secured(read_secured), .power_good(power_good),
    .img_addr(img_addr), .img_data(img_data), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .busy(busy), .done(done), .id_fail(id_fail),
    .verify_fail(verify_fail), .readback_refused(readback_refused));
  jisp_dev_model #(.ERASE_T(ERASE_C / 4 - 1),
    .PROG_T(PROG_C / 4 - 1),
    .VREAD_T(jisp_pkg::VREAD_CYC / 4 - 1),
    .RELOAD_T(RELOAD_C / 4 - 1)) dev (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .secured(read_secured),
    .io_hiz());
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic wait_idle(input int lim);
    int i;
    for (i = 0; i < lim && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == lim) begin
      fail_count++;
      close_out();
    end
  endtask : wait_idle
  task automatic run(input logic vo, input logic tu, input logic rl,
                     input logic sec);
    @(posedge clk);
    #1;
    verify_only = vo;
    target_user = tu;
    reload_now = rl;
    read_secured = sec;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    repeat (100) @(posedge clk);
    #1;
    start = 1'b1;
    check(dev.io_hiz, 1'b1);
    @(posedge clk);
    #1;
    start = 1'b0;
    wait_idle(40000);
    #1;
  endtask : run
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 256; i++) begin
      e0 = $random(seed);
      img[i] = e0[15:0];
    end
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    wait_idle(200);
    start = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    start = 1'b0;
    check(busy, 1'b0);
    $display("test power gate done");
    power_good = 1'b1;
    repeat (4) @(posedge clk);
    run(1'b0, 1'b1, 1'b1, 1'b0);
    check({done, id_fail, verify_fail, readback_refused}, 4'h8);
    check(dev.erase_n, 1);
    check(dev.reload_n, 1);
    check(dev.io_hiz, 1'b0);
    for (int i = 0; i <= int'(jisp_pkg::USR_LAST); i++)
      check(dev.raw(UB + i[15:0]), img[i]);
    check(dev.raw(jisp_pkg::CFG_BASE), 16'hFFFF);
    check(dev.minp >= 40.0, 1'b1);
    $display("test full program done");
    run(1'b1, 1'b1, 1'b0, 1'b1);
    check({done, id_fail, verify_fail, readback_refused}, 4'h8);
    check(dev.erase_n, 1);
    check(dev.reload_n, 1);
    $display("test secured user verify done");
    e0 = $random(seed) & 31;
    dev.mem[UB + e0[15:0]] = img[e0] ^ 16'h0001;
    run(1'b1, 1'b1, 1'b0, 1'b0);
    check({id_fail, verify_fail, readback_refused}, 3'h2);
    $display("test corrupt verify done");
    run(1'b1, 1'b0, 1'b0, 1'b1);
    check({id_fail, readback_refused}, 2'h1);
    $display("test secured readback done");
    dev.id_word = ~jisp_pkg::EXPECT_ID;
    run(1'b0, 1'b1, 1'b0, 1'b0);
    check({id_fail, readback_refused}, 2'h2);
    check(dev.erase_n, 1);
    check(dev.mode, 1'b0);
    $display("test id mismatch done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
